//--- hw/eew_write_path.sv
// i2c client eeprom write path with hardware and software protection
// assumes scl/sda oversampled on mclk; scl high and low each last several mclk
module eew_write_path
   import eew_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = `EEW_WRITE_CYCLES,
   parameter bit          LARGE        = 1'b1
) (
   input  wire logic                 mclk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe_out,
   input  wire logic                 write_protect_in,
   input  wire logic                 client_sel_hi_in,
   input  wire logic                 client_sel_lo_in,
   output logic                      busy_out,
   output logic                      prog_we_out,
   output logic [`EEW_ADDR_W-1:0]    prog_addr_out,
   output logic [`EEW_DATA_W-1:0]    prog_data_out,
   output eew_pkg::eew_prot_s        protect_config_reg_out
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic scl_s, sda_s, wp_s;
   eew_sync u_scl (.clk_in(mclk_in), .d_in(scl_in),           .q_out(scl_s));
   eew_sync u_sda (.clk_in(mclk_in), .d_in(sda_in),           .q_out(sda_s));
   eew_sync u_wp  (.clk_in(mclk_in), .d_in(write_protect_in), .q_out(wp_s));

   logic scl_q, sda_q;
   always_ff @(posedge mclk_in) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
   end
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

   // ------------------------------------------------------------
   // byte engine
   // ------------------------------------------------------------
   eew_link_e             st_q;
   logic [3:0]            bit_q;
   logic [7:0]            sh_q;
   logic                  drive_q;
   logic                  is_prot_q;
   logic [`EEW_ADDR_W-1:0] addr_q;
   logic [4:0]            cnt_q;
   logic [7:0]            first_q;
   logic                  busy_q;
   logic                  word_seen_q;
   eew_job_s              job;

   wire [7:0] byte_now = {sh_q[6:0], sda_s};
   wire       type_ok  = byte_now[7:4] == `EEW_TYPE_ARRAY
                         || byte_now[7:4] == `EEW_TYPE_PROT;
   // small variant: bit 2 is client_sel_lo; large: it is an address bit
   wire       sel_ok   = byte_now[3] == client_sel_hi_in
                         && (LARGE || byte_now[2] == client_sel_lo_in);
   wire       dev_hit  = type_ok && sel_ok && !byte_now[0] && !busy_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_q    <= EEW_IDLE;
         bit_q   <= 4'h0;
         sh_q    <= 8'h00;
         drive_q <= 1'b0;
         is_prot_q <= 1'b0;
         addr_q  <= '0;
         cnt_q   <= 5'h00;
         first_q <= 8'h00;
      end else if (busy_q) begin
         st_q    <= EEW_IDLE; // inputs ignored while programming
         drive_q <= 1'b0;
      end else if (start_ev) begin
         st_q  <= EEW_DEV;
         bit_q <= 4'h0;
         cnt_q <= 5'h00;
      end else if (stop_ev) begin
         st_q    <= EEW_IDLE;
         drive_q <= 1'b0;
         cnt_q   <= 5'h00; // a later bare stop must not replay this job
      end else if (scl_rise && st_q inside {EEW_DEV, EEW_WORD, EEW_DATA}) begin
         sh_q  <= byte_now;
         bit_q <= bit_q + 4'h1;
         if (bit_q == 4'h7) begin
            unique case (st_q)
               EEW_DEV: begin
                  is_prot_q <= byte_now[4];
                  if (LARGE) begin
                     addr_q[9:8] <= byte_now[2:1];
                  end else begin
                     addr_q[9:8] <= {1'b0, byte_now[1]};
                  end
                  st_q <= dev_hit ? EEW_ACK : EEW_SKIP;
               end
               EEW_WORD: begin
                  addr_q[7:0] <= byte_now;
                  st_q        <= EEW_ACK;
               end
               default: begin
                  if (cnt_q == 5'h00) begin
                     first_q <= byte_now;
                  end
                  if (cnt_q != 5'h00) begin
                     addr_q[3:0] <= addr_q[3:0] + 4'h1;
                  end
                  if (cnt_q != 5'h1F) begin
                     cnt_q <= cnt_q + 5'h01;
                  end
                  st_q <= EEW_ACK; // acked regardless
               end
            endcase
         end
      end else if (scl_fall && st_q == EEW_ACK) begin
         drive_q <= ~drive_q;
         if (drive_q) begin
            bit_q <= 4'h0;
            st_q  <= word_seen_q ? EEW_DATA : EEW_WORD;
         end
      end
   end

   // ------------------------------------------------------------
   // ack phase sequencing
   // ------------------------------------------------------------
   // word address taken: later acks lead into data bytes
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || start_ev) begin
         word_seen_q <= 1'b0;
      end else if (scl_rise && st_q == EEW_WORD && bit_q == 4'h7 && !busy_q) begin
         word_seen_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // page buffer
   // ------------------------------------------------------------
   logic       pm_we;
   logic [3:0] pm_raddr_q;
   logic [7:0] pm_rdata;
   assign pm_we = scl_rise && st_q == EEW_DATA && bit_q == 4'h7 && !busy_q;
   eew_page_mem u_page (
      .clk_in   (mclk_in),
      .we_in    (pm_we),
      .waddr_in (cnt_q == 5'h00 ? addr_q[3:0] : addr_q[3:0] + 4'h1),
      .wdata_in (byte_now),
      .raddr_in (pm_raddr_q),
      .rdata_out(pm_rdata)
   );

   // ------------------------------------------------------------
   // protection decision at stop
   // ------------------------------------------------------------
   eew_prot_s prot_q;
   logic [`EEW_ADDR_W-1:0] row_base;
   logic [`EEW_ADDR_W-1:0] lim;
   logic                   sw_hit;
   assign row_base = addr_q;
   always_comb begin
      // protected from lim upward; full array when code 11
      unique case (prot_q.protect_block_code)
         2'h0:    lim = LARGE ? 10'h300 : 10'h180;
         2'h1:    lim = LARGE ? 10'h200 : 10'h100;
         2'h2:    lim = LARGE ? 10'h100 : 10'h080;
         default: lim = 10'h000;
      endcase
      sw_hit = prot_q.sw_protect_enable && row_base >= lim;
   end

   assign job = {is_prot_q, addr_q, cnt_q, first_q};

   wire data_ok   = st_q != EEW_SKIP && job.count != 5'h00 && !busy_q;
   wire arr_write = data_ok && !job.prot_reg;
   wire reg_write = data_ok && job.prot_reg;
   wire arr_go    = arr_write && !wp_s && !sw_hit;
   wire reg_go    = reg_write && job.count == 5'h01
                    && job.base_addr[7:6] == `EEW_WA_PROT_SEL
                    && job.first_data[`EEW_PROT_KEY_BIT]
                    && job.first_data[`EEW_PROT_CONF_BIT] == job.first_data[`EEW_PROT_FRZ_BIT]
                    && !prot_q.protect_freeze_bit;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         prot_q <= `EEW_PROT_RESET;
      end else if (stop_ev && reg_go) begin
         prot_q <= job.first_data[3:0];
      end
   end

   // ------------------------------------------------------------
   // self-timed programming
   // ------------------------------------------------------------
   logic [31:0] tmr_q;
   logic [4:0]  left_q;
   logic [3:0]  off_q;
   logic        we_q;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         busy_q     <= 1'b0;
         tmr_q      <= 32'h0;
         left_q     <= 5'h00;
         off_q      <= 4'h0;
         pm_raddr_q <= 4'h0;
         we_q       <= 1'b0;
         prog_addr_out <= '0;
         prog_data_out <= '0;
      end else if (!busy_q) begin
         we_q <= 1'b0;
         if (stop_ev && arr_go) begin
            busy_q     <= 1'b1;
            tmr_q      <= WRITE_CYCLES;
            left_q     <= (job.count > 5'h10) ? 5'h10 : job.count;
            off_q      <= job.count > 5'h10 ? job.base_addr[3:0] + 4'h1 - 4'h0
                                             : job.base_addr[3:0] - job.count[3:0] + 4'h1;
            pm_raddr_q <= job.count > 5'h10 ? job.base_addr[3:0] + 4'h1
                                             : job.base_addr[3:0] - job.count[3:0] + 4'h1;
         end
      end else begin
         tmr_q <= tmr_q - 32'h1;
         we_q  <= 1'b0;
         if (left_q != 5'h00 && tmr_q[0] != WRITE_CYCLES[0]) begin // read data settled
            we_q          <= 1'b1;
            prog_addr_out <= {addr_q[`EEW_ADDR_W-1:4], off_q};
            prog_data_out <= pm_rdata;
            left_q        <= left_q - 5'h01;
            off_q         <= off_q + 4'h1;
            pm_raddr_q    <= off_q + 4'h1;
         end
         if (tmr_q <= 32'h1) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sda_oe_out <= 1'b0;
         busy_out   <= 1'b0;
         prog_we_out <= 1'b0;
         protect_config_reg_out <= `EEW_PROT_RESET;
      end else begin
         sda_oe_out  <= drive_q;
         busy_out    <= busy_q;
         prog_we_out <= we_q;
         protect_config_reg_out <= prot_q;
      end
   end
   always_ff @(posedge mclk_in) begin
      sda_out <= 1'b0;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   busy_no_ack_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      busy_q |-> !drive_q) else $error("ack driven while programming");
   wp_block_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (stop_ev && !busy_q && wp_s) |=> !busy_q) else $error("protected write started");
   reg_frozen_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      prot_q.protect_freeze_bit |=> $stable(prot_q)) else $error("frozen register changed");
   prog_row_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      we_q |-> prog_addr_out[9:4] == addr_q[9:4]) else $error("write left the row");
   start_prog_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (stop_ev && arr_go && !busy_q) |=> busy_q[*2]) else $error("no cycle at stop");
   sw_range_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (stop_ev && sw_hit && !busy_q) |=> !busy_q) else $error("range write started");
   prog_end_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      $fell(busy_q) |-> $past(tmr_q) <= 32'h1) else $error("cycle ended early");
   reg_multi_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (stop_ev && reg_write && job.count != 5'h01) |=> $stable(prot_q))
      else $error("multi-byte register write taken");
endmodule // eew_write_path

//--- pkg/eew_defines.svh
// constants for the eeprom write path: addresses, fields, timing
// assumes a 10 MHz system clock that also oversamples the i2c lines
`ifndef EEW_DEFINES_SVH
`define EEW_DEFINES_SVH

`define EEW_TYPE_ARRAY     4'hA
`define EEW_TYPE_PROT      4'hB
`define EEW_WA_PROT_SEL    2'h3
`define EEW_PAGE_BITS      4
`define EEW_ADDR_W         10
`define EEW_DATA_W         8
`define EEW_PROT_KEY_BIT   6
`define EEW_PROT_CONF_BIT  5
`define EEW_PROT_EN_BIT    3
`define EEW_PROT_BLK_HI    2
`define EEW_PROT_BLK_LO    1
`define EEW_PROT_FRZ_BIT   0
`define EEW_PROT_RESET     4'h0
`define EEW_CLK_PERIOD_NS  100
`define EEW_WRITE_TIME_NS  5000000
`define EEW_WRITE_CYCLES   ((`EEW_WRITE_TIME_NS + `EEW_CLK_PERIOD_NS - 1) / `EEW_CLK_PERIOD_NS)

`endif

//--- pkg/eew_pkg.sv
// types shared by the eeprom write path
// assumes eew_defines.svh is on the include path
package eew_pkg;
   `include "eew_defines.svh"

   // one write job handed from the link domain at stop
   typedef struct packed {
      logic                     prot_reg;
      logic [`EEW_ADDR_W-1:0]   base_addr;
      logic [`EEW_PAGE_BITS:0]  count;
      logic [`EEW_DATA_W-1:0]   first_data;
   } eew_job_s;

   // protection register contents
   typedef struct packed {
      logic       sw_protect_enable;
      logic [1:0] protect_block_code;
      logic       protect_freeze_bit;
   } eew_prot_s;

   typedef enum logic [2:0] {
      EEW_IDLE, EEW_DEV, EEW_WORD, EEW_DATA, EEW_ACK, EEW_SKIP
   } eew_link_e;
endpackage

//--- hw/eew_sync.sv
// two flip-flop synchroniser for one level
// assumes d_in is asynchronous to clk_in
module eew_sync (
   input  wire logic clk_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_q;

   always_ff @(posedge clk_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
   end
endmodule // eew_sync

//--- hw/eew_page_mem.sv
// 16-byte page buffer, registered read
// assumes single clock, one write port, one read port
module eew_page_mem (
   input  wire logic       clk_in,
   input  wire logic       we_in,
   input  wire logic [3:0] waddr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic [3:0] raddr_in,
   output logic [7:0]      rdata_out
);
   logic [7:0] mem_q [16];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule // eew_page_mem

//--- verif/eew_host_model.sv
// i2c host model: drives scl and pulls sda low, only within frames
// assumes the bench resolves sda as an open-drain wire with a pull-up
module eew_host_model (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // scl stands high and sda is released between frames
   initial begin
      scl_out    = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic start();
      sda_oe_out = 1'b0;
      scl_out    = 1'b1;
      #400 sda_oe_out = 1'b1;
      #400 scl_out = 1'b0;
   endtask

   // msb first at 800 ns per bit so the mclk sampler sees every level
   task automatic send(input logic [7:0] b, output logic ack);
      #600;
      for (int i = 7; i >= 0; i--) begin
         sda_oe_out = ~b[i];
         #200 scl_out = 1'b1;
         #400 scl_out = 1'b0;
         #200;
      end
      sda_oe_out = 1'b0;
      #800 scl_out = 1'b1;
      ack = (sda_in === 1'b0);
      #800 scl_out = 1'b0;
   endtask

   task automatic stop();
      #600 sda_oe_out = 1'b1;
      #200 scl_out = 1'b1;
      #400 sda_oe_out = 1'b0;
      #800;
   endtask
endmodule // eew_host_model

//--- verif/eew_write_path_tb_top.sv
// self-checking bench for the eeprom write path
// assumes eew_pkg compiled first and the host model in eew_host_model.sv
module eew_write_path_tb_top;
   import eew_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned WCYC = 300;
   logic       mclk_in  = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       wp       = 1'b0;
   logic       scl, host_oe, dut_oe, dut_sda, busy, we;
   logic [9:0] paddr;
   logic [7:0] pdata;
   eew_prot_s  prot;
   logic [7:0] dat [16];
   logic [17:0] exp_q [$];
   int         fail_count = 0;
   int         tests_run  = 0;
   int         cycles     = 0;
   int         seed, tries;
   logic [9:0] lo;
   logic [7:0] rv [5] = '{8'h4B, 8'h0C, 8'h4A, 8'h6B, 8'h48};
   int         rn [5] = '{1, 1, 2, 1, 1};
   logic [3:0] re [5] = '{4'hE, 4'hE, 4'hE, 4'hB, 4'hB};
   wire logic  sda_w = (host_oe | (dut_oe & ~dut_sda)) ? 1'b0 : 1'b1;

   always #50 mclk_in = ~mclk_in;

   eew_host_model host (.sda_in(sda_w), .scl_out(scl), .sda_oe_out(host_oe));

   eew_write_path #(.WRITE_CYCLES(WCYC), .LARGE(1'b1)) dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
      .sda_out(dut_sda), .sda_oe_out(dut_oe), .write_protect_in(wp),
      .client_sel_hi_in(1'b1), .client_sel_lo_in(1'b0), .busy_out(busy),
      .prog_we_out(we), .prog_addr_out(paddr), .prog_data_out(pdata),
      .protect_config_reg_out(prot));

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // result watcher: each programmed byte takes the oldest note
   // -----------------------------------------------------------------
   always @(negedge mclk_in) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("[ERR] run exceeded cycle ceiling");
         summarize();
      end else if (we === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected programming", {paddr, pdata}, 18'h3FFFF);
         else check("programmed byte", {paddr, pdata}, exp_q.pop_front());
      end
   end

   // -----------------------------------------------------------------
   // bus helpers
   // -----------------------------------------------------------------
   task automatic frame(input logic [7:0] dev, input logic [7:0] wa, input int n, input bit prog);
      logic       ack;
      logic [9:0] a;
      a = {dev[2:1], wa};
      host.start();
      host.send(dev, ack);
      check("device ack", ack, 1'b1);
      host.send(wa, ack);
      check("word ack", ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         host.send(dat[i], ack);
         check("data ack", ack, 1'b1);
         if (prog) exp_q.push_back({a[9:4], a[3:0] + 4'(i), dat[i]});
      end
      host.stop();
   endtask

   task automatic poll(output int t);
      logic ack;
      t   = 0;
      ack = 1'b0;
      while (ack !== 1'b1 && t < 40) begin
         t++;
         host.start();
         host.send(8'hA8, ack);
         host.stop();
      end
      check("poll ack", ack, 1'b1);
      check("queue drained", 18'(exp_q.size()), 18'h0);
   endtask

   task automatic wr1(input logic [9:0] a, input bit prog);
      dat[0] = 8'($random(seed));
      frame({4'hA, 1'b1, a[9:8], 1'b0}, a[7:0], 1, prog);
      poll(tries);
   endtask

   initial begin
      seed = 11;
      repeat (12) @(negedge mclk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      check("protect reset", prot, 4'h0);
      // byte write, then polling sees busy
      dat[0] = 8'($random(seed));
      frame(8'hAA, 8'h23, 1, 1'b1);
      repeat (10) @(negedge mclk_in);
      check("busy after stop", busy, 1'b1);
      poll(tries);
      check("nack while busy", tries > 1, 1'b1);
      for (int i = 0; i < 16; i++) dat[i] = 8'($random(seed));
      frame(8'hAC, 8'hEE, 3, 1'b1);
      poll(tries);
      // full page; pin raised after stop must not stop it
      frame(8'hA8, 8'h50, 16, 1'b1);
      @(negedge mclk_in) wp = 1'b1;
      poll(tries);
      frame(8'hAA, 8'h40, 2, 1'b0);
      repeat (10) @(negedge mclk_in);
      check("busy with pin", busy, 1'b0);
      poll(tries);
      check("ready at once", tries, 1);
      @(negedge mclk_in) wp = 1'b0;
      // wrong client bits and read bit are not acked
      foreach (rv[k]) if (k < 2) begin
         host.start();
         host.send(k == 0 ? 8'hA0 : 8'hA9, dat[15][0]);
         host.stop();
         check("refused address", dat[15][0], 1'b0);
      end
      // every block code, first protected and last open address
      for (int c = 0; c < 4; c++) begin
         lo     = 10'h300 - 10'(c) * 10'h100;
         dat[0] = 8'h48 | 8'(c << 1);
         frame(8'hBA, 8'hD5, 1, 1'b0);
         poll(tries);
         check("protect code", prot, {1'b1, 2'(c), 1'b0});
         wr1(lo, 1'b0);
         if (c < 3) wr1(lo - 10'h1, 1'b1);
      end
      // rejected register writes, then freezing
      foreach (rv[k]) begin
         dat[0] = rv[k];
         dat[1] = rv[k];
         frame(8'hB8, 8'hC0, rn[k], 1'b0);
         poll(tries);
         check("register table", prot, re[k]);
      end
      wr1(10'h200, 1'b0);
      wr1(10'h1FF, 1'b1);
      summarize();
   end
endmodule // eew_write_path_tb_top
